// ===== hw/urif_regs.sv
`timescale 1ns/100ps
// Operation
// (R01) Port 0 registers decode at base F200 and port 1 at base F300 of data space.
// (R02) Every register read or write holds the processor for at least two cycles.
// (R03) The divisor access bit turns offsets 0 and 1 into the divisor low and high bytes.
// (R04) Reading offset 0 returns the oldest received character, reset value zero.
// (R05) Writing offset 0 loads a character for transmission; that register is write-only.
// (R06) Interrupt enable bit 3 lets modem status changes raise an interrupt.
// (R07) Interrupt enable bit 2 lets overrun, parity, framing and break raise an interrupt.
// (R08) Interrupt enable bit 1 lets the transmit holding ready condition raise an interrupt.
// (R09) Interrupt enable bit 0 gates data available, and time-out while the counter is active.
// (R10) Identification bit 0 reads 0 while an enabled interrupt pends, with the source encoded.
// (R11) The transmit ready interrupt clears on an identification read or a new character.
// (R12) Queue enable turns on 16-word queues; clearing it disables and empties both.
// (R13) The two trigger bits pick a receive threshold of 1, 4, 8 or 14 words.
// (R14) The bit rate is the clock divided by sixteen times the 16-bit divisor.
// (R15) Reads at offset 2 give identification, writes there give queue control.
module urif_regs #(
    parameter bit PORT_ONE = 1'b0
) (
    input  wire logic       CORE_CLK,
    input  wire logic       SRST,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic [7:0] CPU_WDATA,
    input  wire logic       CPU_RD,
    input  wire logic       CPU_WR,
    output logic [7:0]      CPU_RDATA,
    output logic            CPU_WAIT,
    output logic            IRQ,
    input  wire logic       RX_VALID,
    output logic            RX_READY,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_PARITY_ERR,
    input  wire logic       RX_FRAME_ERR,
    input  wire logic       RX_BREAK,
    input  wire logic       RX_TIMEOUT,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    output logic [7:0]      TX_DATA,
    input  wire logic       TX_SHIFT_EMPTY,
    output logic            BAUD_TICK,
    output logic [7:0]      LINE_CTRL,
    output logic [7:0]      EXT_CTRL,
    output logic [7:0]      PIN_DIR,
    output logic [7:0]      RX_TIMEOUT_VAL,
    output logic [7:0]      TX_GAP_VAL,
    output logic            DMA_BURST,
    input  wire logic       CTS_N,
    input  wire logic       DSR_N,
    input  wire logic       RI_N,
    input  wire logic       CD_N,
    output logic            DTR_N,
    output logic            RTS_N,
    output logic            OUT1_N,
    output logic            OUT2_N
);
    localparam logic [15:0] BASE = PORT_ONE ? urif_pkg::BASE_PORT1 : urif_pkg::BASE_PORT0;

    urif_pkg::urif_acc_t acc_state;
    logic [3:0]  int_enable;
    logic [7:0]  line_control;
    logic [4:0]  modem_control;
    logic [7:0]  scratch;
    logic [7:0]  divisor_low_byte;
    logic [7:0]  divisor_high_byte;
    logic [7:0]  extended_control_one;
    logic [7:0]  extended_control_two;
    logic [7:0]  modem_pin_direction;
    logic [7:0]  receive_timeout;
    logic [7:0]  transmit_gap;
    logic        queue_enable;
    logic [1:0]  receive_trigger;
    logic        dma_mode;
    logic [3:0]  line_err;
    logic [3:0]  modem_delta;
    logic [3:0]  modem_prev;
    logic [3:0]  pin_meta;
    logic [3:0]  pin_sync;
    logic        txr_flag;
    logic        txr_empty_prev;
    logic        tmo_flag;
    logic [19:0] baud_cnt;
    logic [7:0]  rd_mux;

    // Address and access decode
    wire        hit       = CPU_ADDR[15:4] == BASE[15:4]; // R01
    wire [3:0]  off       = CPU_ADDR[3:0];
    wire [15:0] off_hot   = 16'h0001 << off;
    wire        req       = hit && (CPU_RD || CPU_WR);
    wire        div_sel   = line_control[urif_pkg::LC_DIV_ACCESS]; // R03
    wire        data_view = off_hot[urif_pkg::OFF_HOLDING] && !div_sel;
    wire        ien_view  = off_hot[urif_pkg::OFF_INT_ENABLE] && !div_sel;

    // Receive and transmit queues
    wire        rx_push;
    wire        rx_ready_q;
    wire        rx_avail;
    wire [7:0]  rx_head;
    wire [4:0]  rx_level;
    wire        tx_ready_q;
    wire [4:0]  tx_level;
    wire        rx_pop;
    wire        tx_push;
    wire        rx_flush;
    wire        tx_flush;

    // Without queueing each side behaves as a one-word holding register
    wire        rx_room = queue_enable ? rx_ready_q : (rx_level == 5'h00); // R12
    wire        tx_room = queue_enable ? tx_ready_q : (tx_level == 5'h00); // R12

    // A transmit write into a full queue keeps the processor waiting
    wire        tx_stall = CPU_WR && data_view && !tx_room;
    wire        commit   = req && (acc_state == urif_pkg::ACC_HOLD) && !tx_stall;
    wire        rd_go    = commit && CPU_RD;
    wire        wr_go    = commit && CPU_WR;

    assign CPU_WAIT = req && !commit; // R02
    assign rx_push  = RX_VALID && rx_room;
    assign RX_READY = rx_room;
    assign rx_pop   = rd_go && data_view; // R04
    assign tx_push  = wr_go && data_view; // R05

    wire        qc_wr    = wr_go && off_hot[urif_pkg::OFF_INT_ID]; // R15
    wire        qc_off   = qc_wr && !CPU_WDATA[urif_pkg::QC_ENABLE];
    assign rx_flush = qc_wr && (CPU_WDATA[urif_pkg::QC_RX_FLUSH] || qc_off); // R12
    assign tx_flush = qc_wr && (CPU_WDATA[urif_pkg::QC_TX_FLUSH] || qc_off); // R12

    urif_fifo #(
        .WIDTH (urif_pkg::FIFO_WIDTH),
        .DEPTH (urif_pkg::FIFO_DEPTH),
        .AW    (urif_pkg::FIFO_AW)
    ) u_rx_fifo (
        .clk       (CORE_CLK),
        .srst      (SRST),
        .flush     (rx_flush),
        .in_valid  (rx_push),
        .in_ready  (rx_ready_q),
        .in_data   (RX_DATA),
        .out_valid (rx_avail),
        .out_ready (rx_pop),
        .out_data  (rx_head),
        .level     (rx_level)
    );

    urif_fifo #(
        .WIDTH (urif_pkg::FIFO_WIDTH),
        .DEPTH (urif_pkg::FIFO_DEPTH),
        .AW    (urif_pkg::FIFO_AW)
    ) u_tx_fifo (
        .clk       (CORE_CLK),
        .srst      (SRST),
        .flush     (tx_flush),
        .in_valid  (tx_push),
        .in_ready  (tx_ready_q),
        .in_data   (CPU_WDATA),
        .out_valid (TX_VALID),
        .out_ready (TX_READY),
        .out_data  (TX_DATA),
        .level     (tx_level)
    );

    // Modem inputs: two flops, then loopback selection
    wire [3:0] pin_raw = {CD_N, RI_N, DSR_N, CTS_N};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin_sync
            always_ff @(posedge CORE_CLK) begin
                if (SRST) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    wire       loop      = modem_control[urif_pkg::MC_LOOPBACK];
    wire [3:0] loop_pins = {modem_control[3], modem_control[2], modem_control[0], modem_control[1]};
    wire [3:0] modem_now = loop ? loop_pins : ~pin_sync;
    wire [3:0] delta_set = {modem_now[3] ^ modem_prev[3], modem_prev[2] & ~modem_now[2],
                            modem_now[1:0] ^ modem_prev[1:0]};

    // Status views
    wire       txr_ready   = tx_level == 5'h00;
    wire       tx_all_idle = txr_ready && TX_SHIFT_EMPTY;
    // Empty queue reads the reset value rather than stale storage
    wire [7:0] rx_shown    = rx_avail ? rx_head : urif_pkg::RST_REG; // R04
    wire [4:0] rx_trig     = urif_pkg::TRIG_LEVEL[receive_trigger];
    wire       rda         = queue_enable ? (rx_level >= rx_trig) : rx_avail; // R13
    wire       tmo_active  = queue_enable || (receive_timeout != 8'h00); // R09
    wire [7:0] line_status = {queue_enable && (|line_err[3:1]), tx_all_idle, txr_ready,
                              line_err, rx_avail};

    wire src_line  = int_enable[urif_pkg::IE_LINE_ERR] && (|line_err); // R07
    wire src_rda   = int_enable[urif_pkg::IE_RX_READY] && rda; // R09
    wire src_tmo   = int_enable[urif_pkg::IE_RX_READY] && tmo_active && tmo_flag; // R09
    wire src_txr   = int_enable[urif_pkg::IE_TX_READY] && txr_flag; // R08
    wire src_modem = int_enable[urif_pkg::IE_MODEM] && (|modem_delta); // R06
    wire any_src   = src_line || src_rda || src_tmo || src_txr || src_modem;

    // Priority: line, data, time-out, transmit ready, modem
    wire [2:0] int_code = src_line ? urif_pkg::ID_LINE :
                          src_rda  ? urif_pkg::ID_RX_DATA :
                          src_tmo  ? urif_pkg::ID_TIMEOUT :
                          src_txr  ? urif_pkg::ID_TX_READY : urif_pkg::ID_MODEM;
    wire [7:0] int_ident = {queue_enable, queue_enable, 2'h0, int_code, !any_src}; // R10

    wire rd_ident = rd_go && off_hot[urif_pkg::OFF_INT_ID];
    wire txr_clr  = (rd_ident && int_code == urif_pkg::ID_TX_READY && !src_line && !src_rda
                     && !src_tmo) || tx_push; // R11
    wire err_clr  = rd_go && off_hot[urif_pkg::OFF_LINE_STAT];
    wire mst_clr  = rd_go && off_hot[urif_pkg::OFF_MODEM_STAT];
    wire [3:0] err_set = {RX_BREAK && rx_push, RX_FRAME_ERR && rx_push,
                          RX_PARITY_ERR && rx_push, RX_VALID && !rx_room};

    always_comb begin
        rd_mux = 8'h00;
        unique case (off)
            urif_pkg::OFF_HOLDING:    rd_mux = div_sel ? divisor_low_byte : rx_shown; // R03 R04
            urif_pkg::OFF_INT_ENABLE: rd_mux = div_sel ? divisor_high_byte : {4'h0, int_enable};
            urif_pkg::OFF_INT_ID:     rd_mux = int_ident; // R15
            urif_pkg::OFF_LINE_CTRL:  rd_mux = line_control;
            urif_pkg::OFF_MODEM_CTRL: rd_mux = {3'h0, modem_control};
            urif_pkg::OFF_LINE_STAT:  rd_mux = line_status;
            urif_pkg::OFF_MODEM_STAT: rd_mux = {modem_now, modem_delta};
            urif_pkg::OFF_SCRATCH:    rd_mux = scratch;
            urif_pkg::OFF_EXT_ONE:    rd_mux = extended_control_one;
            urif_pkg::OFF_EXT_TWO:    rd_mux = {extended_control_two[7], tx_all_idle, txr_ready,
                                                extended_control_two[4], 3'h0,
                                                extended_control_two[0]};
            urif_pkg::OFF_PIN_DIR:    rd_mux = modem_pin_direction;
            urif_pkg::OFF_RX_TIMEOUT: rd_mux = receive_timeout;
            urif_pkg::OFF_TX_GAP:     rd_mux = transmit_gap;
            default:                  rd_mux = 8'h00;
        endcase
    end

    // Access sequencer: data sampled in the first cycle, effects in the last
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            acc_state <= urif_pkg::ACC_IDLE;
            CPU_RDATA <= urif_pkg::RST_REG;
        end else if (acc_state == urif_pkg::ACC_IDLE) begin
            if (req) begin
                acc_state <= urif_pkg::ACC_HOLD; // R02
                CPU_RDATA <= rd_mux;
            end
        end else if (commit || !req) begin
            acc_state <= urif_pkg::ACC_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            int_enable           <= urif_pkg::RST_REG[3:0];
            line_control         <= urif_pkg::RST_REG;
            modem_control        <= urif_pkg::RST_REG[4:0];
            scratch              <= urif_pkg::RST_REG;
            divisor_low_byte     <= urif_pkg::RST_DIVISOR;
            divisor_high_byte    <= urif_pkg::RST_DIVISOR;
            extended_control_one <= urif_pkg::RST_REG;
            extended_control_two <= urif_pkg::RST_REG;
            modem_pin_direction  <= urif_pkg::RST_REG;
            receive_timeout      <= urif_pkg::RST_REG;
            transmit_gap         <= urif_pkg::RST_REG;
            queue_enable         <= 1'b0;
            receive_trigger      <= 2'h0;
            dma_mode             <= 1'b0;
        end else if (wr_go) begin
            if (off_hot[urif_pkg::OFF_HOLDING] && div_sel) divisor_low_byte <= CPU_WDATA; // R03
            if (off_hot[urif_pkg::OFF_INT_ENABLE] && div_sel) divisor_high_byte <= CPU_WDATA;
            if (ien_view) int_enable <= CPU_WDATA[3:0];
            if (off_hot[urif_pkg::OFF_INT_ID]) begin
                queue_enable    <= CPU_WDATA[urif_pkg::QC_ENABLE]; // R12
                receive_trigger <= CPU_WDATA[urif_pkg::QC_TRIG_LOW+:2]; // R13
                dma_mode        <= CPU_WDATA[urif_pkg::QC_DMA] && CPU_WDATA[urif_pkg::QC_ENABLE];
            end
            if (off_hot[urif_pkg::OFF_LINE_CTRL]) line_control <= CPU_WDATA;
            if (off_hot[urif_pkg::OFF_MODEM_CTRL]) modem_control <= CPU_WDATA[4:0];
            if (off_hot[urif_pkg::OFF_SCRATCH]) scratch <= CPU_WDATA;
            if (off_hot[urif_pkg::OFF_EXT_ONE]) extended_control_one <= CPU_WDATA;
            if (off_hot[urif_pkg::OFF_EXT_TWO])
                extended_control_two <= CPU_WDATA & urif_pkg::EXT_TWO_WR_MASK;
            if (off_hot[urif_pkg::OFF_PIN_DIR]) modem_pin_direction <= CPU_WDATA;
            if (off_hot[urif_pkg::OFF_RX_TIMEOUT]) receive_timeout <= CPU_WDATA;
            if (off_hot[urif_pkg::OFF_TX_GAP]) transmit_gap <= CPU_WDATA;
        end
    end

    // Sticky events: a set in the clearing cycle survives
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            line_err       <= 4'h0;
            modem_delta    <= 4'h0;
            modem_prev     <= 4'h0;
            txr_flag       <= 1'b0;
            txr_empty_prev <= 1'b1;
            tmo_flag       <= 1'b0;
            IRQ            <= 1'b0;
        end else begin
            line_err       <= (line_err & {4{!err_clr}}) | err_set; // R07
            modem_delta    <= (modem_delta & {4{!mst_clr}}) | delta_set; // R06
            modem_prev     <= modem_now;
            txr_empty_prev <= txr_ready;
            txr_flag       <= (txr_flag && !txr_clr) || (txr_ready && !txr_empty_prev); // R11
            tmo_flag       <= (tmo_flag && !rx_pop && !rx_push)
                              || (RX_TIMEOUT && tmo_active && rx_avail); // R09
            IRQ            <= any_src; // R10
        end
    end

    // Divider runs only with a nonzero divisor
    wire [15:0] divisor   = {divisor_high_byte, divisor_low_byte};
    wire [19:0] baud_last = {divisor, urif_pkg::BAUD_PRESCALE} - 20'h00001; // R14
    wire        baud_wrap = baud_cnt >= baud_last;

    always_ff @(posedge CORE_CLK) begin
        if (SRST || divisor == 16'h0000) begin
            baud_cnt  <= 20'h00000;
            BAUD_TICK <= 1'b0;
        end else begin
            baud_cnt  <= baud_wrap ? 20'h00000 : baud_cnt + 20'h00001; // R14
            BAUD_TICK <= baud_wrap;
        end
    end

    assign LINE_CTRL      = line_control;
    assign EXT_CTRL       = extended_control_one;
    assign PIN_DIR        = modem_pin_direction;
    assign RX_TIMEOUT_VAL = receive_timeout;
    assign TX_GAP_VAL     = transmit_gap;
    assign DMA_BURST      = dma_mode;
    // Loopback parks the modem outputs inactive
    assign DTR_N          = loop || !modem_control[0];
    assign RTS_N          = loop || !modem_control[1];
    assign OUT1_N         = loop || !modem_control[2];
    assign OUT2_N         = loop || !modem_control[3];
endmodule : urif_regs

// ===== hw/urif_pkg.sv
package urif_pkg;
    // Processor data-space bases of the two port instances
    localparam logic [15:0] BASE_PORT0      = 16'hF200;
    localparam logic [15:0] BASE_PORT1      = 16'hF300;

    localparam logic [3:0]  OFF_HOLDING     = 4'h0;
    localparam logic [3:0]  OFF_INT_ENABLE  = 4'h1;
    localparam logic [3:0]  OFF_INT_ID      = 4'h2;
    localparam logic [3:0]  OFF_LINE_CTRL   = 4'h3;
    localparam logic [3:0]  OFF_MODEM_CTRL  = 4'h4;
    localparam logic [3:0]  OFF_LINE_STAT   = 4'h5;
    localparam logic [3:0]  OFF_MODEM_STAT  = 4'h6;
    localparam logic [3:0]  OFF_SCRATCH     = 4'h7;
    localparam logic [3:0]  OFF_EXT_ONE     = 4'h8;
    localparam logic [3:0]  OFF_EXT_TWO     = 4'h9;
    localparam logic [3:0]  OFF_PIN_DIR     = 4'hA;
    localparam logic [3:0]  OFF_RX_TIMEOUT  = 4'hB;
    localparam logic [3:0]  OFF_TX_GAP      = 4'hC;

    localparam int          IE_RX_READY     = 0;
    localparam int          IE_TX_READY     = 1;
    localparam int          IE_LINE_ERR     = 2;
    localparam int          IE_MODEM        = 3;
    localparam int          QC_ENABLE       = 0;
    localparam int          QC_RX_FLUSH     = 1;
    localparam int          QC_TX_FLUSH     = 2;
    localparam int          QC_DMA          = 3;
    localparam int          QC_TRIG_LOW     = 6;
    localparam int          LC_DIV_ACCESS   = 7;
    localparam int          MC_LOOPBACK     = 4;

    localparam logic [2:0]  ID_LINE         = 3'h3;
    localparam logic [2:0]  ID_RX_DATA      = 3'h2;
    localparam logic [2:0]  ID_TIMEOUT      = 3'h6;
    localparam logic [2:0]  ID_TX_READY     = 3'h1;
    localparam logic [2:0]  ID_MODEM        = 3'h0;

    localparam logic [7:0]  RST_REG         = 8'h00;
    localparam logic [7:0]  RST_DIVISOR     = 8'h00;
    localparam logic [7:0]  EXT_TWO_WR_MASK = 8'h91;

    localparam logic [4:0]  TRIG_LEVEL [4]  = '{5'h01, 5'h04, 5'h08, 5'h0E};

    localparam int          FIFO_WIDTH      = 8;
    localparam int          FIFO_DEPTH      = 16;
    localparam int          FIFO_AW         = 4;

    localparam int          SERIAL_CLK_KHZ  = 14769;
    localparam int          ACCESS_CYCLES   = 2;
    localparam logic [3:0]  BAUD_PRESCALE   = 4'h0;

    typedef enum logic {ACC_IDLE, ACC_HOLD} urif_acc_t;
endpackage : urif_pkg

// ===== hw/urif_fifo.sv
`timescale 1ns/100ps
module urif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = level != DEPTH[AW:0];
    assign out_valid = level != '0;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            level  <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; level guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : urif_fifo

// ===== tb/urif_regs_assertions.sv
`timescale 1ns/100ps
module urif_regs_assertions #(
    parameter bit PORT_ONE = 1'b0
) (
    input wire logic        CORE_CLK,
    input wire logic        SRST,
    input wire logic [15:0] CPU_ADDR,
    input wire logic [7:0]  CPU_WDATA,
    input wire logic        CPU_RD,
    input wire logic        CPU_WR,
    input wire logic        CPU_WAIT,
    input wire logic        IRQ,
    input wire logic        TX_VALID,
    input wire logic        RX_READY,
    input wire logic        BAUD_TICK,
    input wire logic [7:0]  LINE_CTRL
);
    wire logic [15:0] base = PORT_ONE ? urif_pkg::BASE_PORT1 : urif_pkg::BASE_PORT0;
    wire logic        hit  = CPU_ADDR[15:4] == base[15:4];
    wire logic        req  = hit && (CPU_RD || CPU_WR);
    wire logic        done = req && !CPU_WAIT;
    wire logic        norm = !LINE_CTRL[urif_pkg::LC_DIV_ACCESS];

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    chk_wait_first: assert property ($rose(CPU_RD || CPU_WR) && hit |-> CPU_WAIT)
        else $error("access completed in its first cycle");
    chk_two_cycles: assert property (done |-> $past(req && CPU_WAIT))
        else $error("access shorter than two cycles");
    chk_read_answer: assert property ($rose(CPU_RD) && hit |=> !CPU_WAIT)
        else $error("read not answered in its second cycle");
    chk_other_base: assert property (!hit |-> !CPU_WAIT)
        else $error("wait raised for a foreign address");
    chk_reset_quiet: assert property ($fell(SRST) |-> !IRQ && !TX_VALID && RX_READY)
        else $error("outputs not idle after reset");
    // Enable write lands at commit, the request line follows one cycle later
    chk_irq_masked: assert property (done && CPU_WR && norm && CPU_ADDR[3:0] == 4'h1
        && CPU_WDATA == 8'h00 |=> ##1 !IRQ)
        else $error("request line high with all enables cleared");
    chk_tx_queued: assert property (done && CPU_WR && norm && CPU_ADDR[3:0] == 4'h0
        |=> TX_VALID)
        else $error("written character not offered for transmission");
    chk_tick_gap: assert property (BAUD_TICK |=> !BAUD_TICK [*8] ##1 !BAUD_TICK [*7])
        else $error("baud ticks closer than sixteen cycles");

    cov_read: cover property (done && CPU_RD);
    cov_write: cover property (done && CPU_WR);
    cov_tick: cover property (BAUD_TICK);
    cov_irq: cover property (IRQ);
endmodule : urif_regs_assertions

bind urif_regs urif_regs_assertions #(.PORT_ONE(PORT_ONE)) urif_regs_assertions_inst (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA),
    .CPU_RD(CPU_RD), .CPU_WR(CPU_WR), .CPU_WAIT(CPU_WAIT), .IRQ(IRQ), .TX_VALID(TX_VALID),
    .RX_READY(RX_READY), .BAUD_TICK(BAUD_TICK), .LINE_CTRL(LINE_CTRL));

// ===== tb/urif_core_model.sv
`timescale 1ns/100ps
module urif_core_model (
    input  wire logic       CORE_CLK,
    input  wire logic       stall,
    input  wire logic       RX_READY,
    input  wire logic       TX_VALID,
    input  wire logic [7:0] TX_DATA,
    output logic            RX_VALID,
    output logic [7:0]      RX_DATA,
    output logic            RX_PARITY_ERR,
    output logic            RX_FRAME_ERR,
    output logic            RX_BREAK,
    output logic            RX_TIMEOUT,
    output logic            TX_READY,
    output logic            TX_SHIFT_EMPTY
);
    logic [7:0] got [$];

    initial begin
        RX_VALID = 1'b0;
        RX_DATA = 8'hA5;
        {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR} = 3'b000;
        RX_TIMEOUT = 1'b0;
    end

    // Stall models a slow shifter so the queue can back up
    assign TX_READY       = !stall;
    assign TX_SHIFT_EMPTY = !stall && !TX_VALID;

    always @(posedge CORE_CLK) begin
        if (TX_VALID && TX_READY) got.push_back(TX_DATA);
    end

    task automatic send(input logic [7:0] d, input logic [2:0] err);
        @(posedge CORE_CLK);
        RX_VALID <= 1'b1;
        RX_DATA <= d;
        {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR} <= err;
        do @(posedge CORE_CLK); while (RX_READY !== 1'b1);
        RX_VALID <= 1'b0;
        // Stale data would hide a late capture, so invert it
        RX_DATA <= ~d;
        {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR} <= 3'b000;
    endtask : send
endmodule : urif_core_model

// ===== tb/tb_urif_regs.sv
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_urif_regs;
    logic        CORE_CLK, SRST, CPU_RD, CPU_WR, CPU_WAIT, IRQ, RX_VALID, RX_READY;
    logic        TX_VALID, TX_READY, RX_PARITY_ERR, RX_FRAME_ERR, RX_BREAK, RX_TIMEOUT;
    logic        TX_SHIFT_EMPTY, BAUD_TICK, CTS_N, stall;
    logic [15:0] CPU_ADDR;
    logic [7:0]  CPU_WDATA, CPU_RDATA, RX_DATA, TX_DATA, q;
    int          err_total, num_checks;
    time         t0;

    urif_regs #(.PORT_ONE(1'b1)) urif_regs_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
        .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA), .CPU_RD(CPU_RD), .CPU_WR(CPU_WR),
        .CPU_RDATA(CPU_RDATA), .CPU_WAIT(CPU_WAIT), .IRQ(IRQ), .RX_VALID(RX_VALID),
        .RX_READY(RX_READY), .RX_DATA(RX_DATA), .RX_PARITY_ERR(RX_PARITY_ERR),
        .RX_FRAME_ERR(RX_FRAME_ERR), .RX_BREAK(RX_BREAK), .RX_TIMEOUT(RX_TIMEOUT),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
        .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .BAUD_TICK(BAUD_TICK), .LINE_CTRL(), .EXT_CTRL(),
        .PIN_DIR(), .RX_TIMEOUT_VAL(), .TX_GAP_VAL(), .DMA_BURST(), .CTS_N(CTS_N),
        .DSR_N(1'b1), .RI_N(1'b1), .CD_N(1'b1), .DTR_N(), .RTS_N(), .OUT1_N(), .OUT2_N());

    urif_core_model urif_core_model_inst (.CORE_CLK(CORE_CLK), .stall(stall),
        .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAME_ERR(RX_FRAME_ERR),
        .RX_BREAK(RX_BREAK), .RX_TIMEOUT(RX_TIMEOUT), .TX_READY(TX_READY),
        .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY));

    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        CPU_ADDR <= a;
        CPU_WR <= w;
        CPU_RD <= !w;
        CPU_WDATA <= d;
        @(negedge CORE_CLK);
        while (CPU_WAIT !== 1'b0 && n < 200) begin
            @(negedge CORE_CLK);
            n++;
        end
        if (n == 200) err_total++;
        @(posedge CORE_CLK);
        q = CPU_RDATA;
        CPU_RD <= 1'b0;
        CPU_WR <= 1'b0;
    endtask : acc

    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        acc(1'b1, {urif_pkg::BASE_PORT1[15:4], off}, d);
    endtask : wr

    task automatic rd(input logic [3:0] off, input logic [7:0] e);
        acc(1'b0, {urif_pkg::BASE_PORT1[15:4], off}, 8'h00);
        `CHK(q, e)
    endtask : rd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_total++;
        finish_test();
    end

    initial begin
        {SRST, CPU_RD, CPU_WR, CPU_ADDR, CPU_WDATA} = {1'b1, 2'b00, 16'h0000, 8'h00};
        {CTS_N, stall, err_total, num_checks} = {1'b1, 1'b0, 32'd0, 32'd0};
        repeat (20) @(posedge CORE_CLK);
        SRST <= 1'b0;
        rd(4'h1, 8'h00);
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h01);
        rd(4'hD, 8'h00);
        wr(4'h7, 8'hA5);
        acc(1'b1, 16'hF207, 8'h5A);
        rd(4'h7, 8'hA5);
        wr(4'h3, 8'h80);
        wr(4'h0, 8'h01);
        wr(4'h1, 8'h00);
        rd(4'h0, 8'h01);
        @(posedge BAUD_TICK);
        t0 = $time;
        @(posedge BAUD_TICK);
        `CHK(int'((($time - t0) / 5)), 16)
        wr(4'h3, 8'h03);
        rd(4'h0, 8'h00);
        wr(4'h2, 8'hC1);
        rd(4'h2, 8'hC1);
        wr(4'h1, 8'h01);
        urif_core_model_inst.send(8'h96, 3'b000);
        urif_core_model_inst.send(8'h3C, 3'b000);
        rd(4'h2, 8'hC1);
        wr(4'h2, 8'h41);
        rd(4'h2, 8'hC1);
        wr(4'h2, 8'h01);
        rd(4'h2, 8'hC4);
        `CHK(IRQ, 1'b1)
        wr(4'h1, 8'h00);
        rd(4'h2, 8'hC1);
        wr(4'h1, 8'h01);
        rd(4'h0, 8'h96);
        rd(4'h0, 8'h3C);
        rd(4'h2, 8'hC1);
        wr(4'h1, 8'h04);
        urif_core_model_inst.send(8'h55, 3'b001);
        rd(4'h2, 8'hC6);
        acc(1'b0, {urif_pkg::BASE_PORT1[15:4], 4'h5}, 8'h00);
        `CHK(q[2], 1'b1)
        rd(4'h2, 8'hC1);
        rd(4'h0, 8'h55);
        wr(4'h1, 8'h02);
        stall <= 1'b1;
        wr(4'h0, 8'hA7);
        rd(4'h2, 8'hC1);
        stall <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        `CHK(urif_core_model_inst.got.pop_front(), 8'hA7)
        rd(4'h2, 8'hC2);
        rd(4'h2, 8'hC1);
        wr(4'h1, 8'h08);
        CTS_N <= 1'b0;
        repeat (6) @(posedge CORE_CLK);
        rd(4'h2, 8'hC0);
        rd(4'h6, 8'h11);
        rd(4'h2, 8'hC1);
        stall <= 1'b1;
        for (int i = 0; i < 16; i++) wr(4'h0, 8'(i));
        stall <= 1'b0;
        repeat (40) @(posedge CORE_CLK);
        `CHK(urif_core_model_inst.got.size(), 16)
        for (int i = 0; i < 16; i++) `CHK(urif_core_model_inst.got[i], 8'(i))
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h01);
        finish_test();
    end
endmodule : tb_urif_regs
